// file: design/deser_cfg_bank.sv
// Configuration and status register bank of the video link deserializer.
// Assumes a local register port from the control bus slave and a forward channel load strobe.
//
// Function
// [RQ1] Each general output pin shows its stored value only while its enable is set.
// [RQ2] Data path bit 7 set blocks forward channel loads and keeps local values.
// [RQ3] Pass colour sends colour regardless of data enable, disabling protection and audio.
// [RQ4] Data enable polarity bit 1 means active low, 0 means active high.
// [RQ5] Audio generation bit 0 puts packet audio on colour pins, 1 suppresses it.
// [RQ6] Second audio channel enable from bit 0 if override set, else mode pin.
// [RQ7] Data path bit 2 selects 18-bit video, otherwise 24-bit.
// [RQ8] Data path bit 1 selects frame audio transport, otherwise data island transport.
// [RQ9] Data path bit 0 puts second audio data on blue bit 1 pin.
// [RQ10] Data path bits 6 to 0 load from the remote unless override set.
// [RQ11] Checksum enable checks the byte after each line and flags mismatches.
// [RQ12] Self-test clock field selects pixel clock, 33 MHz, reserved, or 25 MHz.
// [RQ13] Self-test enable bit starts the test; errors count in an 8-bit counter.
// [RQ14] Clock high time as master is the programmed count of 50 ns units.
// [RQ15] Low time sets clock low width and the slave data setup time.
// [RQ16] Display timing bit 7 picks sync mode; bits 6 to 4 set sync polarities.
// [RQ17] Dither bits 3,2 enable stages; bits 1,0 disable high precision stages.
// [RQ18] White balance page selects config or colour tables; bits 5,4 enable.
// [RQ19] Audio PLL on while bit 7 is 0; bit 0 picks sampling edge.
// [RQ20] Spread spectrum bit 3 enables; 3-bit field meaning depends on low frequency mode.
// [RQ21] Link errors counted to threshold drop lock; without counting one error drops it.
// [RQ22] Equalizer bit 0 bypasses adaptation so manual stage selects apply.
// [RQ23] Reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
`include "deser_cfg_consts.svh"

module deser_cfg_bank
   import deser_cfg_pkg::*;
#(
   parameter int UNIT_CYCLES = `SCL_UNIT_CYCLES
)(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   output logic      [7:0]  reg_rdata_out,
   input  wire logic        fc_load_in,
   input  wire logic [6:0]  fc_data_in,
   input  wire logic [3:0]  video_pins_in,
   output logic      [3:0]  gpo_pins_out,
   input  wire logic        mode_sel_pin_in,
   input  wire logic        test_pin_in,
   input  wire logic [3:0]  status_in,
   input  wire logic        test_error_in,
   input  wire logic        de_in,
   input  wire logic [23:0] colour_in,
   input  wire logic        checksum_valid_in,
   input  wire logic [7:0]  checksum_byte_in,
   input  wire logic        checksum_clear_in,
   output logic             checksum_error_out,
   output logic             de_active_out,
   output logic             colour_pass_out,
   output logic             protection_enable_out,
   output logic             packet_audio_out,
   output logic             channel_b_enable_out,
   output logic             video_18bit_out,
   output logic             frame_audio_transport_out,
   input  wire logic        channel_b_data_in,
   output logic             blue1_pin_out,
   output test_clk_type     test_clk_sel_out,
   output logic             test_enable_out,
   input  wire logic        scl_run_in,
   output logic             scl_out,
   input  wire logic        setup_start_in,
   output logic             setup_done_out,
   output logic             sync_mode_out,
   output logic [2:0]       sync_polarity_out,
   output logic [3:0]       dither_ctrl_out,
   output wb_page_type      wb_page_out,
   output logic [1:0]       wb_enable_out,
   output logic             audio_pll_on_out,
   output logic             audio_falling_edge_out,
   input  wire logic        low_frequency_mode_in,
   output logic             ssc_enable_out,
   output logic [3:0]       ssc_profile_out,
   output logic [3:0]       mclk_ctrl_out,
   input  wire logic        cdr_lock_in,
   input  wire logic        link_error_in,
   output logic             lock_out,
   output logic             eq_bypass_out,
   output logic [5:0]       eq_manual_out
);

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------
   function automatic logic [7:0] ones_add(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction

   function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
      return v & m;
   endfunction

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   logic [7:0] gpo65_q, gpo87_q, dpath_q, gpc_q, tctl_q, terr_q;
   logic [7:0] sclh_q, scll_q, dith_q, wbal_q, aud_q, ssc_q, mclk_q, lerr_q, eq_q;

   logic wr_gpo65, wr_gpo87, wr_dpath, wr_gpc, wr_tctl, wr_sclh, wr_scll;
   logic wr_dith, wr_wbal, wr_aud, wr_ssc, wr_mclk, wr_lerr, wr_eq;

   assign wr_gpo65 = reg_wr_in && (reg_addr_in == `OFS_GPO_6_5);
   assign wr_gpo87 = reg_wr_in && (reg_addr_in == `OFS_GPO_8_7);
   assign wr_dpath = reg_wr_in && (reg_addr_in == `OFS_DATA_PATH);
   assign wr_gpc   = reg_wr_in && (reg_addr_in == `OFS_GP_CTRL);
   assign wr_tctl  = reg_wr_in && (reg_addr_in == `OFS_TEST_CTRL);
   assign wr_sclh  = reg_wr_in && (reg_addr_in == `OFS_SCL_HIGH);
   assign wr_scll  = reg_wr_in && (reg_addr_in == `OFS_SCL_LOW);
   assign wr_dith  = reg_wr_in && (reg_addr_in == `OFS_DITHER);
   assign wr_wbal  = reg_wr_in && (reg_addr_in == `OFS_WHITE_BAL);
   assign wr_aud   = reg_wr_in && (reg_addr_in == `OFS_AUDIO_CTRL);
   assign wr_ssc   = reg_wr_in && (reg_addr_in == `OFS_SSC_CTRL);
   assign wr_mclk  = reg_wr_in && (reg_addr_in == `OFS_MCLK_OUT);
   assign wr_lerr  = reg_wr_in && (reg_addr_in == `OFS_LINK_ERR);
   assign wr_eq    = reg_wr_in && (reg_addr_in == `OFS_EQ_CTRL);

   // A local write in the same cycle as a remote load wins, so software never loses its value.
   logic       fc_take;
   logic [7:0] dpath_d;
   // [RQ2] Override blocks loads
   assign fc_take = fc_load_in && !dpath_q[`BIT_DP_OVERRIDE];
   // [RQ10] Remote loads bits 6..0
   assign dpath_d = wr_dpath ? reg_wdata_in :
                    fc_take  ? {dpath_q[7], fc_data_in} : dpath_q;

   // [RQ23] Reserved bits masked
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         gpo65_q <= `RST_GPO;
         gpo87_q <= `RST_GPO;
         dpath_q <= `RST_DATA_PATH;
         tctl_q  <= `RST_TEST_CTRL;
         sclh_q  <= `RST_SCL_HIGH;
         scll_q  <= `RST_SCL_LOW;
         dith_q  <= `RST_ZERO;
         wbal_q  <= `RST_ZERO;
         aud_q   <= `RST_ZERO;
         ssc_q   <= `RST_ZERO;
         mclk_q  <= `RST_ZERO;
         lerr_q  <= `RST_LINK_ERR;
         eq_q    <= `RST_EQ_CTRL;
      end
      else
      begin
         dpath_q <= dpath_d;
         if (wr_gpo65) gpo65_q <= masked(reg_wdata_in, `MASK_GPO);
         if (wr_gpo87) gpo87_q <= masked(reg_wdata_in, `MASK_GPO);
         if (wr_tctl)  tctl_q  <= masked(reg_wdata_in, `MASK_TEST_CTRL);
         if (wr_sclh)  sclh_q  <= reg_wdata_in;
         if (wr_scll)  scll_q  <= reg_wdata_in;
         if (wr_dith)  dith_q  <= reg_wdata_in;
         if (wr_wbal)  wbal_q  <= masked(reg_wdata_in, `MASK_WHITE_BAL);
         if (wr_aud)   aud_q   <= masked(reg_wdata_in, `MASK_AUDIO_CTRL);
         if (wr_ssc)   ssc_q   <= masked(reg_wdata_in, `MASK_SSC_CTRL);
         if (wr_mclk)  mclk_q  <= masked(reg_wdata_in, `MASK_MCLK_OUT);
         if (wr_lerr)  lerr_q  <= masked(reg_wdata_in, `MASK_LINK_ERR);
         if (wr_eq)    eq_q    <= masked(reg_wdata_in, `MASK_EQ_CTRL);
      end
   end

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   // Three stages; the filtered level moves only when stages two and three agree.
   logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
         pin_s3_q <= 2'h0;
         pin_q    <= 2'h0;
      end
      else
      begin
         pin_s1_q <= {test_pin_in, mode_sel_pin_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         if (pin_s2_q[0] == pin_s3_q[0]) pin_q[0] <= pin_s3_q[0];
         if (pin_s2_q[1] == pin_s3_q[1]) pin_q[1] <= pin_s3_q[1];
      end
   end

   // ------------------------------------------------------------------
   // Data path decode
   // ------------------------------------------------------------------
   // [RQ1] Override only when enabled
   assign gpo_pins_out[0] = gpo65_q[0] ? gpo65_q[3] : video_pins_in[0];
   assign gpo_pins_out[1] = gpo65_q[4] ? gpo65_q[7] : video_pins_in[1];
   assign gpo_pins_out[2] = gpo87_q[0] ? gpo87_q[3] : video_pins_in[2];
   assign gpo_pins_out[3] = gpo87_q[4] ? gpo87_q[7] : video_pins_in[3];

   // [RQ3] Pass colour mode
   assign colour_pass_out       = dpath_q[`BIT_DP_PASS_COLOUR];
   assign protection_enable_out = !dpath_q[`BIT_DP_PASS_COLOUR];
   // [RQ5] Packet audio gating
   assign packet_audio_out = !dpath_q[`BIT_DP_NO_AUDIO] && !dpath_q[`BIT_DP_PASS_COLOUR];
   // [RQ4] Data enable polarity
   assign de_active_out = (de_in ^ dpath_q[`BIT_DP_DE_POL]) || dpath_q[`BIT_DP_PASS_COLOUR];
   // [RQ6] Channel B source
   assign channel_b_enable_out = dpath_q[`BIT_DP_CHB_OVR] ? dpath_q[`BIT_DP_CHB_EN] : pin_q[0];
   // [RQ7] Video width
   assign video_18bit_out = dpath_q[`BIT_DP_18BIT];
   // [RQ8] Audio transport
   assign frame_audio_transport_out = dpath_q[`BIT_DP_FRAME_AUD];
   // [RQ9] Channel B on blue 1
   assign blue1_pin_out = channel_b_enable_out ? channel_b_data_in : gpo_pins_out[1];

   // ------------------------------------------------------------------
   // Line checksum
   // ------------------------------------------------------------------
   logic [7:0] csum_q;
   logic       csum_err_q;
   logic       csum_bad;

   // [RQ11] Compare line checksum
   assign csum_bad = gpc_q[`BIT_GP_CHECKSUM] && checksum_valid_in && (checksum_byte_in != ~csum_q);

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         csum_q     <= 8'h00;
         csum_err_q <= 1'b0;
         gpc_q      <= `RST_GP_CTRL;
      end
      else
      begin
         if (checksum_valid_in)
            csum_q <= 8'h00;
         else if (de_active_out)
            csum_q <= ones_add(ones_add(ones_add(csum_q, colour_in[7:0]), colour_in[15:8]), colour_in[23:16]);
         // A mismatch in the clearing cycle keeps the flag set.
         if (csum_bad)
            csum_err_q <= 1'b1;
         else if (checksum_clear_in)
            csum_err_q <= 1'b0;
         gpc_q <= {wr_gpc ? reg_wdata_in[7] : gpc_q[7], 2'b00, 1'b1, status_in};
      end
   end
   assign checksum_error_out = csum_err_q;

   // ------------------------------------------------------------------
   // Self-test
   // ------------------------------------------------------------------
   logic test_en, test_en_q;
   // [RQ12] Clock source select
   assign test_clk_sel_out = test_clk_type'(tctl_q[2:1]);
   // [RQ13] Test enable source
   assign test_en         = tctl_q[3] ? pin_q[1] : tctl_q[0];
   assign test_enable_out = test_en;

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         terr_q    <= 8'h00;
         test_en_q <= 1'b0;
      end
      else
      begin
         test_en_q <= test_en;
         // [RQ13] Count errors, saturate
         if (test_en && !test_en_q)
            terr_q <= 8'h00;
         else if (test_en && test_error_in && terr_q != 8'hFF)
            terr_q <= terr_q + 8'h01;
      end
   end

   // ------------------------------------------------------------------
   // Local I2C clock timing
   // ------------------------------------------------------------------
   // Units are whole 50 ns steps rounded up, so widths never fall short of the minimum.
   scl_state_type scl_st_q;
   logic [15:0]   scl_cnt_q, setup_cnt_q;
   logic [15:0]   high_cyc, low_cyc;
   logic          setup_busy_q, setup_done_q;

   // [RQ14] High width in units
   assign high_cyc = 16'(sclh_q) * 16'(UNIT_CYCLES);
   // [RQ15] Low width in units
   assign low_cyc  = 16'(scll_q) * 16'(UNIT_CYCLES);

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         scl_st_q     <= SCL_HIGH;
         scl_cnt_q    <= 16'h0000;
         setup_cnt_q  <= 16'h0000;
         setup_busy_q <= 1'b0;
         setup_done_q <= 1'b0;
      end
      else
      begin
         case (scl_st_q)
            SCL_HIGH:
            begin
               if (!scl_run_in)
                  scl_cnt_q <= 16'h0000;
               else if (scl_cnt_q + 16'h0001 >= high_cyc)
               begin
                  scl_cnt_q <= 16'h0000;
                  scl_st_q  <= SCL_LOW;
               end
               else
                  scl_cnt_q <= scl_cnt_q + 16'h0001;
            end
            SCL_LOW:
            begin
               if (scl_cnt_q + 16'h0001 >= low_cyc)
               begin
                  scl_cnt_q <= 16'h0000;
                  scl_st_q  <= SCL_HIGH;
               end
               else
                  scl_cnt_q <= scl_cnt_q + 16'h0001;
            end
            default:
               scl_st_q <= SCL_HIGH;
         endcase
         // [RQ15] Slave setup time
         setup_done_q <= 1'b0;
         if (setup_start_in)
         begin
            setup_busy_q <= 1'b1;
            setup_cnt_q  <= 16'h0000;
         end
         else if (setup_busy_q)
         begin
            if (setup_cnt_q + 16'h0001 >= low_cyc)
            begin
               setup_busy_q <= 1'b0;
               setup_done_q <= 1'b1;
            end
            else
               setup_cnt_q <= setup_cnt_q + 16'h0001;
         end
      end
   end
   assign scl_out        = (scl_st_q == SCL_HIGH);
   assign setup_done_out = setup_done_q;

   // ------------------------------------------------------------------
   // Display, dither, white balance, audio, spread spectrum, equalizer
   // ------------------------------------------------------------------
   // [RQ16] Timing mode, polarities
   assign sync_mode_out     = dith_q[7];
   assign sync_polarity_out = dith_q[6:4];
   // [RQ17] Dither stage controls
   assign dither_ctrl_out   = dith_q[3:0];
   // [RQ18] White balance page
   assign wb_page_out       = wb_page_type'(wbal_q[7:6]);
   assign wb_enable_out     = wbal_q[5:4];
   // [RQ19] PLL and edge select
   assign audio_pll_on_out       = !aud_q[7];
   assign audio_falling_edge_out = aud_q[0];
   // [RQ20] Spread spectrum profile
   assign ssc_enable_out  = ssc_q[3];
   assign ssc_profile_out = {low_frequency_mode_in, ssc_q[2:0]};
   assign mclk_ctrl_out   = mclk_q[7:4];
   // [RQ22] Equalizer bypass
   assign eq_bypass_out   = eq_q[0];
   assign eq_manual_out   = eq_q[0] ? {eq_q[7:5], eq_q[3:1]} : 6'h00;

   // ------------------------------------------------------------------
   // Link error lock
   // ------------------------------------------------------------------
   logic [3:0] lerr_cnt_q;
   logic       lock_lost_q;
   logic       lose_now;

   // [RQ21] Threshold or single error
   assign lose_now = link_error_in &&
                     (!lerr_q[`BIT_LE_ENABLE] || (lerr_cnt_q + 4'h1 >= lerr_q[3:0]));

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         lerr_cnt_q  <= 4'h0;
         lock_lost_q <= 1'b0;
      end
      else if (!cdr_lock_in)
      begin
         lerr_cnt_q  <= 4'h0;
         lock_lost_q <= 1'b0;
      end
      else
      begin
         if (lose_now)
            lock_lost_q <= 1'b1;
         if (link_error_in && lerr_cnt_q != 4'hF)
            lerr_cnt_q <= lerr_cnt_q + 4'h1;
      end
   end
   assign lock_out = cdr_lock_in && !lock_lost_q;

   // ------------------------------------------------------------------
   // Read back
   // ------------------------------------------------------------------
   // Unmapped offsets read as zero.
   assign reg_rdata_out = (reg_addr_in == `OFS_GPO_6_5)   ? gpo65_q :
                          (reg_addr_in == `OFS_GPO_8_7)   ? gpo87_q :
                          (reg_addr_in == `OFS_DATA_PATH) ? dpath_q :
                          (reg_addr_in == `OFS_GP_CTRL)   ? gpc_q   :
                          (reg_addr_in == `OFS_TEST_CTRL) ? tctl_q  :
                          (reg_addr_in == `OFS_TEST_ERRS) ? terr_q  :
                          (reg_addr_in == `OFS_SCL_HIGH)  ? sclh_q  :
                          (reg_addr_in == `OFS_SCL_LOW)   ? scll_q  :
                          (reg_addr_in == `OFS_DITHER)    ? dith_q  :
                          (reg_addr_in == `OFS_WHITE_BAL) ? wbal_q  :
                          (reg_addr_in == `OFS_AUDIO_CTRL)? aud_q   :
                          (reg_addr_in == `OFS_SSC_CTRL)  ? ssc_q   :
                          (reg_addr_in == `OFS_MCLK_OUT)  ? mclk_q  :
                          (reg_addr_in == `OFS_LINK_ERR)  ? lerr_q  :
                          (reg_addr_in == `OFS_EQ_CTRL)   ? eq_q    : 8'h00;

endmodule // deser_cfg_bank

// file: pkg/deser_cfg_consts.svh
// Register offsets, field positions, reset values and timing counts for the configuration bank.
// Assumes the bank runs on a single 250 MHz clock.
`ifndef DESER_CFG_CONSTS_SVH
`define DESER_CFG_CONSTS_SVH

`define OFS_GPO_6_5        8'h20
`define OFS_GPO_8_7        8'h21
`define OFS_DATA_PATH      8'h22
`define OFS_GP_CTRL        8'h23
`define OFS_TEST_CTRL      8'h24
`define OFS_TEST_ERRS      8'h25
`define OFS_SCL_HIGH       8'h26
`define OFS_SCL_LOW        8'h27
`define OFS_DITHER         8'h29
`define OFS_WHITE_BAL      8'h2A
`define OFS_AUDIO_CTRL     8'h2B
`define OFS_SSC_CTRL       8'h2C
`define OFS_MCLK_OUT       8'h3A
`define OFS_LINK_ERR       8'h41
`define OFS_EQ_CTRL        8'h44

`define RST_GPO            8'h00
`define RST_DATA_PATH      8'h00
`define RST_GP_CTRL        8'h10
`define RST_TEST_CTRL      8'h08
`define RST_SCL_HIGH       8'h83
`define RST_SCL_LOW        8'h84
`define RST_LINK_ERR       8'h03
`define RST_EQ_CTRL        8'h60
`define RST_ZERO           8'h00

`define MASK_GPO           8'h99
`define MASK_GP_CTRL_RW    8'h80
`define MASK_TEST_CTRL     8'h0F
`define MASK_WHITE_BAL     8'hF0
`define MASK_AUDIO_CTRL    8'h81
`define MASK_SSC_CTRL      8'h0F
`define MASK_MCLK_OUT      8'hF0
`define MASK_LINK_ERR      8'h1F
`define MASK_EQ_CTRL       8'hEF

`define BIT_DP_OVERRIDE    7
`define BIT_DP_PASS_COLOUR 6
`define BIT_DP_DE_POL      5
`define BIT_DP_NO_AUDIO    4
`define BIT_DP_CHB_OVR     3
`define BIT_DP_18BIT       2
`define BIT_DP_FRAME_AUD   1
`define BIT_DP_CHB_EN      0
`define BIT_GP_CHECKSUM    7
`define BIT_LE_ENABLE      4

`define CLK_PERIOD_PS      4000
`define SCL_UNIT_PS        50000
`define SCL_UNIT_CYCLES    ((`SCL_UNIT_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// file: pkg/deser_cfg_pkg.sv
// Types shared by the configuration bank.
// Assumes the constants header is included alongside.
package deser_cfg_pkg;
   typedef enum logic [1:0] {
      TEST_CLK_PIXEL = 2'b00,
      TEST_CLK_OSC33 = 2'b01,
      TEST_CLK_RSVD  = 2'b10,
      TEST_CLK_OSC25 = 2'b11
   } test_clk_type;

   typedef enum logic [1:0] {
      WB_PAGE_CONFIG = 2'b00,
      WB_PAGE_RED    = 2'b01,
      WB_PAGE_GREEN  = 2'b10,
      WB_PAGE_BLUE   = 2'b11
   } wb_page_type;

   typedef enum logic [0:0] {
      SCL_HIGH = 1'b0,
      SCL_LOW  = 1'b1
   } scl_state_type;
endpackage

// file: sim/deser_cfg_bank_assertions.sv
// Checker for the configuration bank: data path, readback and equalizer ports.
// Assumes it is bound to deser_cfg_bank and sees only that module's ports.
`timescale 1ns/1ps
module deser_cfg_bank_assertions (
   input wire logic       sys_clk_in,
   input wire logic       rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_wr_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       fc_load_in,
   input wire logic [6:0] fc_data_in,
   input wire logic       video_18bit_out,
   input wire logic       colour_pass_out,
   input wire logic       de_active_out,
   input wire logic       eq_bypass_out,
   input wire logic [5:0] eq_manual_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   logic dp_wr;
   logic ovr_q;
   // A remote load keeps bit 7, so the override copy follows local writes only.
   assign dp_wr = reg_wr_in && reg_addr_in == 8'h22;
   always_ff @(posedge sys_clk_in)
      ovr_q <= rst_in ? 1'b0 : (dp_wr ? reg_wdata_in[7] : ovr_q);
   a_write_sets_width: assert property (dp_wr |=> video_18bit_out == $past(reg_wdata_in[2]))
      else $error("width missed write");
   a_load_taken: assert property (fc_load_in && !ovr_q && !dp_wr |=> video_18bit_out == $past(fc_data_in[2]))
      else $error("load not taken");
   a_load_blocked: assert property (fc_load_in && ovr_q && !dp_wr |=> $stable(video_18bit_out))
      else $error("load not blocked");
   a_override_reads: assert property (reg_addr_in == 8'h22 |-> reg_rdata_out[7] == ovr_q)
      else $error("override readback");
   a_local_readback: assert property (dp_wr ##1 reg_addr_in == 8'h22 |-> reg_rdata_out == $past(reg_wdata_in))
      else $error("data path readback");
   a_reserved_zero: assert property (reg_addr_in == 8'h20 |-> (reg_rdata_out & 8'h66) == 8'h00)
      else $error("reserved bits set");
   a_pass_colour_de: assert property (colour_pass_out |-> de_active_out)
      else $error("pass colour lost enable");
   a_eq_manual_idle: assert property (!eq_bypass_out |-> eq_manual_out == 6'h00)
      else $error("manual select leaked");
endmodule // deser_cfg_bank_assertions

bind deser_cfg_bank deser_cfg_bank_assertions u_chk (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
   .reg_wr_in, .reg_rdata_out, .fc_load_in, .fc_data_in, .video_18bit_out, .colour_pass_out, .de_active_out,
   .eq_bypass_out, .eq_manual_out);

// file: sim/deser_cfg_bank_tb.sv
// Bench for the configuration bank: access masks, forward loads, pins, self-test and lock.
// Assumes the checker binds itself; UNIT_CYCLES is cut to 1.
`timescale 1ns/1ps
module deser_cfg_bank_tb;
   logic        sys_clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        reg_wr_in = 1'b0, de_in = 1'b1, test_error_in = 1'b0, link_error_in = 1'b0, cdr_lock_in = 1'b1;
   logic [7:0]  reg_addr_in = 8'h20, reg_wdata_in = 8'h00, reg_rdata_out;
   logic [3:0]  video_pins_in = 4'hA, gpo_pins_out;
   logic [36:0] noise_q = 37'h0;
   logic        de_active_out, video_18bit_out, test_enable_out, lock_out;
   wire logic       fc_load_in;
   wire logic [6:0] fc_data_in;
   int          error_cnt = 0, comparisons = 0;
   logic [7:0]  ofs [15] = '{8'h20,8'h21,8'h22,8'h23,8'h24,8'h25,8'h26,8'h27,8'h29,8'h2A,8'h2B,8'h2C,8'h3A,8'h41,8'h44};
   logic [7:0]  rv [15] = '{8'h00,8'h00,8'h00,8'h10,8'h08,8'h00,8'h83,8'h84,8'h00,8'h00,8'h00,8'h00,8'h00,8'h03,8'h60};
   logic [7:0]  msk [15] = '{8'h99,8'h99,8'hFF,8'h80,8'h0F,8'h00,8'hFF,8'hFF,8'hFF,8'hF0,8'h81,8'h0F,8'hF0,8'h1F,8'hEF};

   deser_cfg_bank #(.UNIT_CYCLES(1)) uut (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rdata_out, .fc_load_in, .fc_data_in, .video_pins_in, .gpo_pins_out, .mode_sel_pin_in(1'b0),
      .test_pin_in(1'b0), .status_in(4'h0), .test_error_in, .de_in, .colour_in(noise_q[23:0]),
      .checksum_valid_in(noise_q[35]), .checksum_byte_in(noise_q[31:24]), .checksum_clear_in(noise_q[36]),
      .checksum_error_out(), .de_active_out, .colour_pass_out(), .protection_enable_out(), .packet_audio_out(),
      .channel_b_enable_out(), .video_18bit_out, .frame_audio_transport_out(), .channel_b_data_in(noise_q[33]),
      .blue1_pin_out(), .test_clk_sel_out(), .test_enable_out, .scl_run_in(noise_q[34]), .scl_out(),
      .setup_start_in(1'b0), .setup_done_out(), .sync_mode_out(), .sync_polarity_out(), .dither_ctrl_out(),
      .wb_page_out(), .wb_enable_out(), .audio_pll_on_out(), .audio_falling_edge_out(),
      .low_frequency_mode_in(noise_q[32]), .ssc_enable_out(), .ssc_profile_out(), .mclk_ctrl_out(),
      .cdr_lock_in, .link_error_in, .lock_out, .eq_bypass_out(), .eq_manual_out());
   remote_ser_model rs (.clk_in(sys_clk_in), .fc_load_out(fc_load_in), .fc_data_out(fc_data_in));

   initial
      forever #2 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in)
      noise_q <= #1 noise_q * 37'h5 + 37'h3;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      error_cnt += int'(got !== exp);
      if (got !== exp)
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_in) #1 {reg_addr_in, reg_wdata_in, reg_wr_in} = {a, d, 1'b1};
      @(posedge sys_clk_in) #1 reg_wr_in = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk_in) #1 reg_addr_in = a;
      #1 chk(reg_rdata_out, e);
   endtask
   task automatic blip(ref logic s);
      @(posedge sys_clk_in) #1 s = 1'b1;
      @(posedge sys_clk_in) #1 s = 1'b0;
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      logic [7:0] v;
      repeat (4) @(posedge sys_clk_in);
      #1 rst_in = 1'b0;
      for (int i = 0; i < 15; i++)
         rd(ofs[i], rv[i]);
      $display("Test reset values done");
      for (int p = 0; p < 2; p++)
      begin
         v = p ? 8'h00 : 8'hFF;
         for (int i = 0; i < 15; i++)
            wr(ofs[i], v);
         wr(8'h28, ~v);
         for (int i = 0; i < 15; i++)
            rd(ofs[i], (v & msk[i]) | (i == 3 ? 8'h10 : 8'h00));
      end
      $display("Test access masks done");
      rs.send(7'h04, 0);
      rd(8'h22, 8'h04);
      chk(8'(video_18bit_out), 8'h01);
      wr(8'h22, 8'hA0);
      #1 chk(8'(de_active_out), 8'h00);
      rs.send(7'h7F, 3);
      rd(8'h22, 8'hA0);
      wr(8'h22, 8'hC0);
      de_in = 1'b0;
      #1 chk(8'(de_active_out), 8'h01);
      $display("Test data path done");
      wr(8'h20, 8'h19);
      wr(8'h21, 8'h09);
      chk(8'(gpo_pins_out), 8'h0D);
      wr(8'h24, 8'h01);
      repeat (3) blip(test_error_in);
      rd(8'h25, 8'h03);
      chk(8'(test_enable_out), 8'h01);
      $display("Test pins and self-test done");
      chk(8'(lock_out), 8'h01);
      blip(link_error_in);
      chk(8'(lock_out), 8'h00);
      cdr_lock_in = 1'b0;
      wr(8'h41, 8'h13);
      cdr_lock_in = 1'b1;
      repeat (2) blip(link_error_in);
      chk(8'(lock_out), 8'h01);
      blip(link_error_in);
      chk(8'(lock_out), 8'h00);
      $display("Test link lock done");
      wrap_up();
   end
endmodule // deser_cfg_bank_tb

// file: sim/remote_ser_model.sv
// Remote serializer model loading the data path bits over the forward channel.
// Assumes a one-cycle load strobe sampled on the rising clock edge.
`timescale 1ns/1ps
module remote_ser_model (
   input  wire logic  clk_in,
   output logic       fc_load_out,
   output logic [6:0] fc_data_out
);
   initial
      {fc_load_out, fc_data_out} = 8'h00;
   // Remote data load.
   // Data is inverted once released so a late sample never sees the old value.
   task automatic send(input logic [6:0] d, input int gap);
      repeat (gap) @(posedge clk_in);
      @(posedge clk_in) #1 {fc_load_out, fc_data_out} = {1'b1, d};
      @(posedge clk_in) #1 {fc_load_out, fc_data_out} = {1'b0, ~d};
   endtask
endmodule // remote_ser_model
